// ### rtl/xp_pkg.sv
package xp_pkg;
  localparam logic [6:0] addr_base       = 7'h20;
  localparam int         ptr_w           = 3;
  localparam logic [2:0] reg_input0      = 3'h0;
  localparam logic [7:0] out_reset       = 8'hff;
  localparam logic [7:0] pol_reset       = 8'h00;
  localparam logic [7:0] cfg_reset       = 8'hff;
  localparam int         sys_clk_hz      = 40000000;
  localparam int         scl_half_ns     = 1250;
  localparam int         sys_period_ns   = 25;
  localparam int         scl_half_cycles = (scl_half_ns + sys_period_ns - 1) / sys_period_ns;
endpackage : xp_pkg

// ### rtl/xp_link_if.sv
`timescale 1ns/1ps
interface xp_link_if;
  logic scl_o;     // master drives clock (push-pull, no stretching)
  logic sda_m_o;   // master sda value
  logic sda_m_oe;  // master pulls sda low
  logic sda_t_o;   // target sda value
  logic sda_t_oe;  // target pulls sda low
  wire  sda = ~((sda_m_oe & ~sda_m_o) | (sda_t_oe & ~sda_t_o));
  modport master (output scl_o, output sda_m_o, output sda_m_oe, input sda);
  modport target (input scl_o, output sda_t_o, output sda_t_oe, input sda);
endinterface : xp_link_if

// ### rtl/xp_target.sv
`timescale 1ns/1ps
module xp_target (
  input  wire logic        sys_clk,   // system clock
  input  wire logic        rstn,      // sync reset, low
  xp_link_if.target        link,      // i2c pins
  input  wire logic        addr_sel,  // address select pin
  input  wire logic [15:0] in_port,   // input port levels
  output logic      [15:0] out_reg,   // output port registers
  output logic      [15:0] pol_reg,   // polarity registers
  output logic      [15:0] cfg_reg,   // configuration registers
  output logic             wr_pulse   // one cycle at each committed write
);
  typedef enum logic [2:0] {idle_s, addr_s, cmd_s, wdata_s, rdata_s, ack_s, rack_s, skip_s}
    ph_type;
  typedef struct packed {
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic [1:0]  asel_s;
    logic [15:0] in_s0;
    logic [15:0] in_s1;
    logic        scl_d;
    logic        sda_d;
    ph_type      ph;
    ph_type      after_ack;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        rd;
    logic        sda_low;
    logic [2:0]  ptr;
    logic [2:0]  cur;
    logic [15:0] outr;
    logic [15:0] polr;
    logic [15:0] cfgr;
    logic        wp;
  } st_type;
  st_type s_reg, s_next;

  function automatic logic [7:0] reg_read(input logic [2:0] p, input st_type s);
    logic [15:0] w;
    w = 16'h0000;
    case (p[2:1])
      2'd0:    w = s.in_s1;
      2'd1:    w = s.outr;
      2'd2:    w = s.polr;
      default: w = s.cfgr;
    endcase
    reg_read = p[0] ? w[15:8] : w[7:0];
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  always_comb begin
    scl      = s_reg.scl_s[1];
    sda      = s_reg.sda_s[1];
    scl_rise = scl & ~s_reg.scl_d;
    scl_fall = ~scl & s_reg.scl_d;
    start_c  = scl & s_reg.scl_d & s_reg.sda_d & ~sda;
    stop_c   = scl & s_reg.scl_d & ~s_reg.sda_d & sda;
  end

  always_comb begin
    s_next       = s_reg;
    s_next.scl_s = {s_reg.scl_s[0], link.scl_o};
    s_next.sda_s = {s_reg.sda_s[0], link.sda};
    // pins from outside the clock domain pass two flops before use
    s_next.asel_s = {s_reg.asel_s[0], addr_sel};
    s_next.in_s0  = in_port;
    s_next.in_s1  = s_reg.in_s0;
    s_next.scl_d = scl;
    s_next.sda_d = sda;
    s_next.wp    = 1'b0;
    if (stop_c) begin
      s_next.ph      = idle_s;
      s_next.sda_low = 1'b0;
    end else if (start_c) begin
      if (s_reg.ph != idle_s) s_next.ptr = s_reg.cur;
      s_next.ph      = addr_s;
      s_next.bitn    = 4'd0;
      s_next.sda_low = 1'b0;
    end else if (scl_rise) begin
      case (s_reg.ph)
        addr_s, cmd_s, wdata_s: begin
          s_next.sh   = {s_reg.sh[6:0], sda};
          s_next.bitn = s_reg.bitn + 4'd1;
        end
        rack_s: begin
          // nack from master ends the read; the bus goes quiet until stop/restart
          if (sda) s_next.ph = skip_s;
          else begin
            s_next.cur = {s_reg.cur[2:1], ~s_reg.cur[0]};
            s_next.sh  = reg_read({s_reg.cur[2:1], ~s_reg.cur[0]}, s_reg);
          end
        end
        ack_s: if (s_reg.after_ack == rdata_s) begin
          s_next.sh = reg_read(s_reg.cur, s_reg);
        end
        default: s_next.ph = s_reg.ph;
      endcase
    end else if (scl_fall) begin
      case (s_reg.ph)
        addr_s: if (s_reg.bitn == 4'd8) begin
          if (s_reg.sh[7:1] == {xp_pkg::addr_base[6:1], s_reg.asel_s[1]}) begin
            s_next.rd        = s_reg.sh[0];
            s_next.after_ack = s_reg.sh[0] ? rdata_s : cmd_s;
            s_next.cur       = s_reg.ptr;
            s_next.ph        = ack_s;
            s_next.sda_low   = 1'b1;
          end else s_next.ph = skip_s;
        end
        cmd_s: if (s_reg.bitn == 4'd8) begin
          s_next.ptr       = s_reg.sh[2:0];
          s_next.cur       = s_reg.sh[2:0];
          s_next.after_ack = wdata_s;
          s_next.ph        = ack_s;
          s_next.sda_low   = 1'b1;
        end
        wdata_s: if (s_reg.bitn == 4'd8) begin
          s_next.wp = 1'b1;
          case (s_reg.cur) // inputs are read-only, writes to them are dropped
            3'd2: s_next.outr[7:0]  = s_reg.sh;
            3'd3: s_next.outr[15:8] = s_reg.sh;
            3'd4: s_next.polr[7:0]  = s_reg.sh;
            3'd5: s_next.polr[15:8] = s_reg.sh;
            3'd6: s_next.cfgr[7:0]  = s_reg.sh;
            3'd7: s_next.cfgr[15:8] = s_reg.sh;
            default: s_next.wp = 1'b0;
          endcase
          s_next.ph        = ack_s;
          s_next.after_ack = wdata_s;
          s_next.sda_low   = 1'b1;
        end
        ack_s: begin
          s_next.bitn = 4'd0;
          s_next.ph   = s_reg.after_ack;
          if (s_reg.after_ack == rdata_s) s_next.sda_low = ~s_reg.sh[7];
          else s_next.sda_low = 1'b0;
          if (s_reg.after_ack == rdata_s) s_next.bitn = 4'd1;
        end
        rdata_s: begin
          if (s_reg.bitn == 4'd8) begin
            s_next.ph      = rack_s;
            s_next.sda_low = 1'b0;
          end else begin
            s_next.sda_low = ~s_reg.sh[7 - s_reg.bitn[2:0]];
            s_next.bitn    = s_reg.bitn + 4'd1;
          end
        end
        rack_s: begin
          s_next.ph      = rdata_s;
          s_next.bitn    = 4'd1;
          s_next.sda_low = ~s_reg.sh[7];
        end
        default: s_next.ph = s_reg.ph;
      endcase
    end
    // advance to partner after each write byte, committed or dropped
    if (s_reg.wp || (s_reg.ph == wdata_s && s_next.ph == ack_s && s_next.wp == 1'b0
        && scl_fall && s_reg.bitn == 4'd8))
      s_next.cur = {s_reg.cur[2:1], ~s_reg.cur[0]};
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_reg           <= '0;
      s_reg.scl_s     <= 2'b11;
      s_reg.sda_s     <= 2'b11;
      s_reg.scl_d     <= 1'b1;
      s_reg.sda_d     <= 1'b1;
      s_reg.ph        <= idle_s;
      s_reg.after_ack <= idle_s;
      s_reg.ptr       <= xp_pkg::reg_input0;
      s_reg.cur       <= xp_pkg::reg_input0;
      s_reg.outr      <= {2{xp_pkg::out_reset}};
      s_reg.polr      <= {2{xp_pkg::pol_reset}};
      s_reg.cfgr      <= {2{xp_pkg::cfg_reset}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.sda_t_o  = 1'b0;
  assign link.sda_t_oe = s_reg.sda_low;
  assign out_reg       = s_reg.outr;
  assign pol_reg       = s_reg.polr;
  assign cfg_reg       = s_reg.cfgr;
  assign wr_pulse      = s_reg.wp;
endmodule : xp_target

// ### rtl/xp_master.sv
`timescale 1ns/1ps
module xp_master (
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rstn,      // sync reset, low
  xp_link_if.master       link,      // i2c pins
  input  wire logic       cmd_valid, // start a transaction
  input  wire logic       cmd_rd,    // 1 = read, 0 = write
  input  wire logic       cmd_sel,   // target address select bit
  input  wire logic [7:0] cmd_len,   // data byte count (>=1)
  input  wire logic       cmd_ptr_en,// send command byte (read: then restart; writes send it always)
  input  wire logic [2:0] cmd_ptr,   // command byte value
  input  wire logic [7:0] wr_data,   // write byte, sampled on the edge that raises wr_take
  output logic            busy,      // transaction running
  output logic            wr_take,   // pulse: wr_data consumed
  output logic            rd_valid,  // pulse: rd_data valid
  output logic [7:0]      rd_data,   // received byte
  output logic            nack_err   // pulse: target did not acknowledge
);
  typedef enum logic [2:0] {idle_s, start_s, byte_s, ack_s, stop_s, fin_s} mph_type;
  typedef struct packed {
    mph_type    ph;
    logic [6:0] div;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [1:0] stage;
    logic       rd;
    logic       sel;
    logic [7:0] left;
    logic       pe;
    logic [2:0] ptr;
    logic       scl;
    logic       sda;
    logic       busy;
    logic       wt;
    logic       rv;
    logic [7:0] rdd;
    logic       ne;
    logic [1:0] sda_s;
  } mst_type;
  mst_type m_reg, m_next;
  logic tick;
  logic sda_in;

  // stage: 0 address write, 1 command, 2 address of data phase, 3 data
  always_comb begin
    m_next       = m_reg;
    m_next.sda_s = {m_reg.sda_s[0], link.sda};
    sda_in       = m_reg.sda_s[1];
    m_next.wt    = 1'b0;
    m_next.rv    = 1'b0;
    m_next.ne    = 1'b0;
    tick         = (m_reg.div == 7'(xp_pkg::scl_half_cycles / 2 - 1));
    m_next.div   = tick ? 7'd0 : m_reg.div + 7'd1;
    if (m_reg.ph == idle_s) begin
      m_next.div = 7'd0;
      if (cmd_valid) begin
        m_next       = m_reg;
        m_next.sda_s = {m_reg.sda_s[0], link.sda};
        m_next.ph    = start_s;
        m_next.q     = 2'd0;
        m_next.rd    = cmd_rd;
        m_next.sel   = cmd_sel;
        m_next.left  = cmd_len;
        m_next.pe    = cmd_ptr_en;
        m_next.ptr   = cmd_ptr;
        m_next.busy  = 1'b1;
        m_next.stage = (cmd_ptr_en || !cmd_rd) ? 2'd0 : 2'd2;
        m_next.sh    = {xp_pkg::addr_base[6:1], cmd_sel, (cmd_ptr_en || !cmd_rd) ? 1'b0 : 1'b1};
        m_next.div   = 7'd0;
      end
    end else if (tick) begin
      m_next.q = m_reg.q + 2'd1;
      case (m_reg.ph)
        start_s: case (m_reg.q) // sda high, scl high, sda low, scl low
          2'd0: m_next.sda = 1'b1;
          2'd1: m_next.scl = 1'b1;
          2'd2: m_next.sda = 1'b0;
          default: begin
            m_next.scl  = 1'b0;
            m_next.ph   = byte_s;
            m_next.bitn = 4'd0;
          end
        endcase
        byte_s: case (m_reg.q)
          2'd0: m_next.sda = (m_reg.stage == 2'd3 && m_reg.rd) ? 1'b1 : m_reg.sh[7];
          2'd1: m_next.scl = 1'b1;
          2'd2: if (m_reg.stage == 2'd3 && m_reg.rd) m_next.sh = {m_reg.sh[6:0], sda_in};
                else m_next.sh = {m_reg.sh[6:0], 1'b0};
          default: begin
            m_next.scl  = 1'b0;
            m_next.bitn = m_reg.bitn + 4'd1;
            if (m_reg.bitn == 4'd7) m_next.ph = ack_s;
          end
        endcase
        ack_s: case (m_reg.q)
          2'd0: if (m_reg.stage == 2'd3 && m_reg.rd) begin
                  m_next.sda = (m_reg.left == 8'd1);
                  m_next.rdd = m_reg.sh;
                  m_next.rv  = 1'b1;
                end else m_next.sda = 1'b1;
          2'd1: m_next.scl = 1'b1;
          2'd2: if (!(m_reg.stage == 2'd3 && m_reg.rd) && sda_in) m_next.ne = 1'b1;
          default: begin
            m_next.scl  = 1'b0;
            m_next.bitn = 4'd0;
            m_next.ph   = byte_s;
            // ne was a one-cycle pulse, so the nack level is looked at again
            if (!(m_reg.stage == 2'd3 && m_reg.rd) && sda_in) m_next.ph = stop_s;
            else case (m_reg.stage)
              2'd0: begin
                m_next.stage = 2'd1;
                m_next.sh    = {5'd0, m_reg.ptr};
              end
              2'd1: if (m_reg.rd) begin
                m_next.stage = 2'd2;
                m_next.ph    = start_s;
                m_next.sh    = {xp_pkg::addr_base[6:1], m_reg.sel, 1'b1};
              end else begin
                m_next.stage = 2'd3;
                m_next.sh    = wr_data;
                m_next.wt    = 1'b1;
              end
              2'd2: begin
                m_next.stage = 2'd3;
                if (!m_reg.rd) begin
                  m_next.sh = wr_data;
                  m_next.wt = 1'b1;
                end
              end
              default: begin
                m_next.left = m_reg.left - 8'd1;
                if (m_reg.left == 8'd1) m_next.ph = stop_s;
                else if (!m_reg.rd) begin
                  m_next.sh = wr_data;
                  m_next.wt = 1'b1;
                end
              end
            endcase
          end
        endcase
        stop_s: case (m_reg.q)
          2'd0: m_next.sda = 1'b0;
          2'd1: m_next.scl = 1'b1;
          2'd2: m_next.sda = 1'b1;
          default: m_next.ph = fin_s;
        endcase
        default: begin
          m_next.ph   = idle_s;
          m_next.busy = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      m_reg       <= '0;
      m_reg.ph    <= idle_s;
      m_reg.scl   <= 1'b1;
      m_reg.sda   <= 1'b1;
      m_reg.sda_s <= 2'b11;
    end else begin
      m_reg <= m_next;
    end
  end

  assign link.scl_o    = m_reg.scl;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = ~m_reg.sda;
  assign busy          = m_reg.busy;
  assign wr_take       = m_reg.wt;
  assign rd_valid      = m_reg.rv;
  assign rd_data       = m_reg.rdd;
  assign nack_err      = m_reg.ne;
endmodule : xp_master

// ### verif/xp_link_sva.sv
`timescale 1ns/1ps
module xp_link_sva (
  input wire logic sys_clk,  // system clock
  input wire logic rstn,     // sync reset, low
  input wire logic scl_o,    // bus clock from master
  input wire logic sda_t_oe, // target pulls sda low
  input wire logic sda       // resolved data line
);
  logic       scl_d;
  logic       sda_d;
  logic       ak;
  logic       rw;
  logic [3:0] cnt;
  logic [1:0] byt;
  logic [7:0] sh;
  wire        st  = scl_o && scl_d && sda_d && !sda;
  wire        sp  = scl_o && scl_d && !sda_d && sda;
  wire        rs  = scl_o && !scl_d;
  wire        ack = rs && cnt == 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // bit and byte tracking from the wire only, so both ends are judged alike
  always_ff @(posedge sys_clk) begin
    scl_d <= scl_o;
    sda_d <= sda;
    if (st) begin
      cnt <= 4'h0;
      byt <= 2'h0;
      ak  <= 1'b0;
    end else if (ack) begin
      cnt <= 4'h0;
      if (byt != 2'h3) begin
        byt <= byt + 2'h1;
      end
      if (byt == 2'h0) begin
        ak <= !sda;
        rw <= sh[0];
      end
    end else if (rs) begin
      cnt <= cnt + 4'h1;
      sh  <= {sh[6:0], sda};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_t_hold_high: assert property (scl_o && scl_d |-> $stable(sda_t_oe))
    else $error("target moved sda while scl high");
  chk_addr_only: assert property (ack && byt == 2'h0 && !sda |-> sh[7:2] == 6'h10)
    else $error("foreign address acknowledged");
  chk_addr_by_t: assert property (ack && byt == 2'h0 && !sda |-> sda_t_oe)
    else $error("address ack not driven by target");
  chk_wr_acked: assert property (ack && byt != 2'h0 && ak && !rw |-> !sda)
    else $error("written byte not acknowledged");
  chk_rd_release: assert property (ack && byt != 2'h0 && rw |-> !sda_t_oe)
    else $error("target holds sda in master ack slot");
  chk_stop_free: assert property (sp |=> !sda_t_oe)
    else $error("target holds sda after stop");
  chk_start_hold: assert property (st |-> scl_o [*8])
    else $error("scl fell too soon after start");
  chk_scl_high: assert property (rs |-> scl_o [*8])
    else $error("scl high phase too short");
endmodule : xp_link_sva

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        addr_sel = 1'b1;
  logic [15:0] in_port = 16'h0000;
  logic        cmd_valid = 1'b0;
  logic        cmd_rd = 1'b0;
  logic        cmd_sel = 1'b1;
  logic [7:0]  cmd_len = 8'h01;
  logic        cmd_ptr_en = 1'b0;
  logic [2:0]  cmd_ptr = 3'h0;
  logic [7:0]  wr_data = 8'h00;
  logic        busy;
  logic        wr_take;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        nack_err;
  logic [15:0] out_reg;
  logic [15:0] pol_reg;
  logic [15:0] cfg_reg;
  logic        wr_pulse;
  int          err_count = 0;
  int          checked = 0;
  int          nack_exp = 0;
  int          nack_got = 0;
  logic [7:0]  m [8];
  logic [2:0]  sp = 3'h0;
  logic [7:0]  exp_r [$];
  logic [47:0] exp_w [$];
  logic [7:0]  wq [$];

  always #12.5 sys_clk = ~sys_clk;

  xp_link_if link ();
  xp_master xp_master_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
    .cmd_valid(cmd_valid), .cmd_rd(cmd_rd), .cmd_sel(cmd_sel), .cmd_len(cmd_len),
    .cmd_ptr_en(cmd_ptr_en), .cmd_ptr(cmd_ptr), .wr_data(wr_data), .busy(busy),
    .wr_take(wr_take), .rd_valid(rd_valid), .rd_data(rd_data), .nack_err(nack_err));
  xp_target xp_target_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
    .addr_sel(addr_sel), .in_port(in_port), .out_reg(out_reg), .pol_reg(pol_reg),
    .cfg_reg(cfg_reg), .wr_pulse(wr_pulse));
  xp_link_sva xp_link_sva_inst (.sys_clk(sys_clk), .rstn(rstn), .scl_o(link.scl_o),
    .sda_t_oe(link.sda_t_oe), .sda(link.sda));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (e !== g) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // model notes expectations first, then runs one master command
  task automatic xfer(input bit rd, input bit sel, input int len, input bit pen,
                      input logic [2:0] ptr);
    logic [2:0]  p;
    logic [15:0] iv;
    logic [7:0]  d;
    bit          ok;
    int          n;
    p = pen ? ptr : sp;
    ok = (sel == addr_sel);
    wq.delete();
    iv = 16'($urandom);
    if (rd) begin
      in_port <= iv;
      m[0] = iv[7:0];
      m[1] = iv[15:8];
    end
    if (ok) sp = p;
    else nack_exp++;
    for (n = 0; n < len; n++) begin
      d = 8'($urandom);
      wq.push_back(d);
      if (ok && rd) exp_r.push_back(m[p]);
      if (ok && !rd && p > 3'h1) begin
        m[p] = d;
        exp_w.push_back({m[3], m[2], m[5], m[4], m[7], m[6]});
      end
      p = p ^ 3'h1;
    end
    wr_data <= wq.pop_front();
    cmd_rd <= rd;
    cmd_sel <= sel;
    cmd_len <= len[7:0];
    cmd_ptr_en <= pen;
    cmd_ptr <= ptr;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // busy may lag the take by an edge, so it is not trusted at first
    for (n = 0; n < 40000; n++) begin
      @(posedge sys_clk);
      if (wr_take === 1'b1 && wq.size() > 0) wr_data <= wq.pop_front();
      if (n > 3 && busy === 1'b0) break;
    end
    if (n == 40000) begin
      chk("xfer_timeout", 48'h0, 48'h1);
      final_report();
    end
    repeat (20) @(posedge sys_clk);
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_r.size() == 0) chk("rd_extra", 48'h0, 48'h1);
      else chk("rd_data", {40'h0, exp_r.pop_front()}, {40'h0, rd_data});
    end
    if (wr_pulse === 1'b1) begin
      if (exp_w.size() == 0) chk("wr_extra", 48'h0, 48'h1);
      else chk("regs", exp_w.pop_front(), {out_reg, pol_reg, cfg_reg});
    end
    if (nack_err === 1'b1) nack_got++;
  end

  initial begin
    int i;
    void'($urandom(62589));
    m[2] = xp_pkg::out_reset;
    m[3] = xp_pkg::out_reset;
    m[4] = xp_pkg::pol_reset;
    m[5] = xp_pkg::pol_reset;
    m[6] = xp_pkg::cfg_reset;
    m[7] = xp_pkg::cfg_reset;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk("regs_reset", {m[3], m[2], m[5], m[4], m[7], m[6]}, {out_reg, pol_reg, cfg_reg});
    // input reads run first: polarity stays at its default for them
    xfer(1'b1, 1'b1, 2, 1'b1, 3'h0);
    // pointer now rests on the first input register: read it without a command
    xfer(1'b1, 1'b1, 3, 1'b0, 3'h0);
    for (i = 0; i < 8; i++) begin
      xfer(1'b0, 1'b1, 2, 1'b1, i[2:0]);
      xfer(1'b1, 1'b1, 1, 1'b1, i[2:0]);
    end
    xfer(1'b0, 1'b1, 5, 1'b1, 3'h3);
    addr_sel <= 1'b0;
    @(posedge sys_clk);
    xfer(1'b0, 1'b1, 1, 1'b1, 3'h4);
    xfer(1'b0, 1'b0, 2, 1'b1, 3'h6);
    xfer(1'b1, 1'b0, 2, 1'b0, 3'h0);
    chk("nack", 48'(nack_exp), 48'(nack_got));
    chk("pending", 48'h0, 48'(exp_r.size() + exp_w.size()));
    final_report();
  end
endmodule : tb_top
